// *** mlac_map.svh ***
// register offsets, field positions and reset values of the motion block
`ifndef MLAC_MAP_SVH
`define MLAC_MAP_SVH
`define MLAC_OFS_XU 8'h00
`define MLAC_OFS_YU 8'h04
`define MLAC_OFS_ZU 8'h08
`define MLAC_OFS_XL 8'h0c
`define MLAC_OFS_XH 8'h10
`define MLAC_OFS_YL 8'h14
`define MLAC_OFS_YH 8'h18
`define MLAC_OFS_ZL 8'h1c
`define MLAC_OFS_ZH 8'h20
`define MLAC_OFS_TL 8'h24
`define MLAC_OFS_TH 8'h28
`define MLAC_OFS_STAT 8'h2c
`define MLAC_OFS_CFG 8'h30
`define MLAC_OFS_ATHR 8'h34
`define MLAC_OFS_ITHR 8'h38
`define MLAC_OFS_ATIM 8'h3c
`define MLAC_OFS_ITIM 8'h40
`define MLAC_OFS_FDAT 8'h44
`define MLAC_OFS_FCNT 8'h48
// config fields
`define MLAC_CFG_ACT_EN 0
`define MLAC_CFG_INACT_EN 1
`define MLAC_CFG_ACT_REF 2
`define MLAC_CFG_INACT_REF 3
`define MLAC_CFG_LINK_LO 4
`define MLAC_CFG_LINK_HI 5
`define MLAC_CFG_AUTOSLEEP 6
`define MLAC_CFG_MAP_LO 7
`define MLAC_CFG_MAP_HI 8
`define MLAC_CFG_FTRIG 9
`define MLAC_CFG_W 10
`define MLAC_CFG_RST 10'h000
// awake pin routing codes
`define MLAC_MAP_PIN1 2'h1
`define MLAC_MAP_PIN2 2'h2
// reset values
`define MLAC_ATHR_RST 11'h000
`define MLAC_ITHR_RST 11'h000
`define MLAC_ATIM_RST 8'h00
`define MLAC_ITIM_RST 16'h0000
`define MLAC_AWAKE_RST 1'b1
// store geometry
`define MLAC_FDEPTH 512
`define MLAC_FCNT_FULL 10'h200
`define MLAC_TAG_X 2'h0
`define MLAC_TAG_Y 2'h1
`define MLAC_TAG_Z 2'h2
`endif

// *** mlac_pkg.sv ***
// types shared by the motion block
package mlac_pkg;
   typedef enum logic [1:0] {lk_default, lk_linked, lk_loop} mlac_link_t;
   typedef enum logic [1:0] {ph_idle, ph_x, ph_y, ph_z} mlac_phase_t;
   typedef logic [11:0] mlac_smp_t;
endpackage : mlac_pkg

// *** mlac_top.sv ***
// motion, linking, autosleep and sample store logic with apb registers
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "mlac_map.svh"
module mlac_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_clk,
   input wire mlac_pkg::mlac_smp_t x_in,
   input wire mlac_pkg::mlac_smp_t y_in,
   input wire mlac_pkg::mlac_smp_t z_in,
   input wire mlac_pkg::mlac_smp_t t_in,
   output logic irq_pin_one,
   output logic irq_pin_two,
   output logic wakeup_mode
);
   import mlac_pkg::*;

   // distance of a sample from its reference
   function automatic logic [12:0] mlac_dev(input mlac_smp_t a,
                                            input mlac_smp_t b);
      logic signed [12:0] d;
      d = $signed({a[11], a}) - $signed({b[11], b});
      mlac_dev = d[12] ? 13'(-d) : 13'(d);
   endfunction : mlac_dev

   function automatic mlac_link_t mlac_link(input logic [1:0] f);
      mlac_link = (f == 2'h0) ? lk_default :
                  (f == 2'h1) ? lk_linked : lk_loop;
   endfunction : mlac_link

   ////////////////////////////////////////////////////////////////////////////
   // sample clock and data synchronisers
   logic sclk_s1, sclk_s2, sclk_s3;
   mlac_smp_t xs1, ys1, zs1, ts1, xs2, ys2, zs2, ts2;
   mlac_smp_t x_s, y_s, z_s, t_s;
   logic new_smp;
   wire sclk_rise = sclk_s2 & ~sclk_s3;

   // data are taken two flops late; the sensor holds them over the edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
         {xs1, ys1, zs1, ts1} <= 48'h0;
         {xs2, ys2, zs2, ts2} <= 48'h0;
      end
      else
      begin
         sclk_s1 <= sample_clk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         {xs1, ys1, zs1, ts1} <= {x_in, y_in, z_in, t_in};
         {xs2, ys2, zs2, ts2} <= {xs1, ys1, zs1, ts1};
      end
   end

   // both views come from the same latched sample
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {x_s, y_s, z_s, t_s} <= 48'h0;
         new_smp <= 1'b0;
      end
      else
      begin
         new_smp <= sclk_rise;
         if (sclk_rise)
            {x_s, y_s, z_s, t_s} <= {xs2, ys2, zs2, ts2};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state
   logic [`MLAC_CFG_W-1:0] cfg;
   logic [10:0] act_thr, inact_thr;
   logic [7:0] act_time;
   logic [15:0] inact_time;
   logic act_pend, inact_pend, awake, frozen;
   logic [8:0] wp, rp;
   logic [9:0] fcnt;
   logic [15:0] fmem [0:`MLAC_FDEPTH-1];
   logic [31:0] rd_mux;
   logic rd_hit;

   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire stat_rd = rd & (paddr == `MLAC_OFS_STAT);
   wire fifo_rd = rd & (paddr == `MLAC_OFS_FDAT);
   wire fempty = (fcnt == 10'h000);
   wire ffull = (fcnt == `MLAC_FCNT_FULL);
   wire [15:0] fhead = fmem[rp];

   // register views
   always_comb
   begin
      rd_hit = 1'b1;
      rd_mux = 32'h0;
      if (paddr == `MLAC_OFS_XU) rd_mux = {24'h0, x_s[11:4]};
      else if (paddr == `MLAC_OFS_YU) rd_mux = {24'h0, y_s[11:4]};
      else if (paddr == `MLAC_OFS_ZU) rd_mux = {24'h0, z_s[11:4]};
      else if (paddr == `MLAC_OFS_XL) rd_mux = {24'h0, x_s[7:0]};
      else if (paddr == `MLAC_OFS_XH) rd_mux = {24'h0, {4{x_s[11]}}, x_s[11:8]};
      else if (paddr == `MLAC_OFS_YL) rd_mux = {24'h0, y_s[7:0]};
      else if (paddr == `MLAC_OFS_YH) rd_mux = {24'h0, {4{y_s[11]}}, y_s[11:8]};
      else if (paddr == `MLAC_OFS_ZL) rd_mux = {24'h0, z_s[7:0]};
      else if (paddr == `MLAC_OFS_ZH) rd_mux = {24'h0, {4{z_s[11]}}, z_s[11:8]};
      else if (paddr == `MLAC_OFS_TL) rd_mux = {24'h0, t_s[7:0]};
      else if (paddr == `MLAC_OFS_TH) rd_mux = {24'h0, {4{t_s[11]}}, t_s[11:8]};
      else if (paddr == `MLAC_OFS_STAT)
         rd_mux = {27'h0, frozen, wakeup_mode, awake, inact_pend, act_pend};
      else if (paddr == `MLAC_OFS_CFG) rd_mux = {22'h0, cfg};
      else if (paddr == `MLAC_OFS_ATHR) rd_mux = {21'h0, act_thr};
      else if (paddr == `MLAC_OFS_ITHR) rd_mux = {21'h0, inact_thr};
      else if (paddr == `MLAC_OFS_ATIM) rd_mux = {24'h0, act_time};
      else if (paddr == `MLAC_OFS_ITIM) rd_mux = {16'h0, inact_time};
      else if (paddr == `MLAC_OFS_FDAT)
         rd_mux = fempty ? 32'h0 : {16'h0, fhead};
      else if (paddr == `MLAC_OFS_FCNT) rd_mux = {22'h0, fcnt};
      else rd_hit = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~rd_hit;
         if (psel & penable & ~pready & ~pwrite)
            prdata <= rd_mux;
      end
   end

   // writable registers; the store entry read ahead is popped on completion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg <= `MLAC_CFG_RST;
         act_thr <= `MLAC_ATHR_RST;
         inact_thr <= `MLAC_ITHR_RST;
         act_time <= `MLAC_ATIM_RST;
         inact_time <= `MLAC_ITIM_RST;
      end
      else if (wr)
      begin
         if (paddr == `MLAC_OFS_CFG) cfg <= pwdata[`MLAC_CFG_W-1:0];
         else if (paddr == `MLAC_OFS_ATHR) act_thr <= pwdata[10:0];
         else if (paddr == `MLAC_OFS_ITHR) inact_thr <= pwdata[10:0];
         else if (paddr == `MLAC_OFS_ATIM) act_time <= pwdata[7:0];
         else if (paddr == `MLAC_OFS_ITIM) inact_time <= pwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // detection control
   wire mlac_link_t link = mlac_link(cfg[`MLAC_CFG_LINK_HI:`MLAC_CFG_LINK_LO]);
   wire act_en = cfg[`MLAC_CFG_ACT_EN];
   wire inact_en = cfg[`MLAC_CFG_INACT_EN];
   wire any_pend = act_pend | inact_pend;
   wire chained = (link != lk_default);
   wire sleep_ok = cfg[`MLAC_CFG_AUTOSLEEP] & chained;
   wire hold_off = (link == lk_linked) & any_pend;
   // chained modes arm only the detector the awake state expects
   wire act_run = act_en & (~chained | (~awake & ~hold_off));
   wire inact_run = inact_en & (~chained | (awake & ~hold_off));

   mlac_smp_t arx, ary, arz, irx, iry, irz;
   logic act_arm, inact_arm;
   logic [7:0] acnt;
   logic [15:0] icnt;

   // absolute compare uses a zero reference
   wire a_ref = cfg[`MLAC_CFG_ACT_REF];
   wire i_ref = cfg[`MLAC_CFG_INACT_REF];
   wire [12:0] adx = mlac_dev(x_s, a_ref ? arx : 12'h000);
   wire [12:0] ady = mlac_dev(y_s, a_ref ? ary : 12'h000);
   wire [12:0] adz = mlac_dev(z_s, a_ref ? arz : 12'h000);
   wire [12:0] idx = mlac_dev(x_s, i_ref ? irx : 12'h000);
   wire [12:0] idy = mlac_dev(y_s, i_ref ? iry : 12'h000);
   wire [12:0] idz = mlac_dev(z_s, i_ref ? irz : 12'h000);
   wire [12:0] athr = {2'h0, act_thr};
   wire [12:0] ithr = {2'h0, inact_thr};
   wire act_over = (adx > athr) | (ady > athr) | (adz > athr);
   wire inact_in = (idx <= ithr) & (idy <= ithr) & (idz <= ithr);
   // time of zero behaves as one sample
   wire act_hit = wakeup_mode |
                  ({1'b0, acnt} + 9'h001 >= {1'b0, act_time});
   wire inact_hit = ({1'b0, icnt} + 17'h00001 >= {1'b0, inact_time});
   wire act_ev = new_smp & act_run & act_arm & act_over & act_hit;
   wire inact_ev = new_smp & inact_run & inact_arm & inact_in & inact_hit;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_arm <= 1'b0;
         inact_arm <= 1'b0;
         acnt <= 8'h00;
         icnt <= 16'h0000;
         {arx, ary, arz, irx, iry, irz} <= 72'h0;
      end
      else if (new_smp)
      begin
         // each new arming takes a fresh reference and restarts counting
         act_arm <= act_run & ~act_ev;
         inact_arm <= inact_run & ~inact_ev;
         if (!act_run | !act_arm | act_ev | !act_over)
            acnt <= 8'h00;
         else
            acnt <= acnt + 8'h01;
         if (act_run & (!act_arm | act_ev))
            {arx, ary, arz} <= {x_s, y_s, z_s};
         if (!inact_run | !inact_arm | inact_ev | !inact_in)
            icnt <= 16'h0000;
         else
            icnt <= icnt + 16'h0001;
         if (inact_run & (!inact_arm | inact_ev))
            {irx, iry, irz} <= {x_s, y_s, z_s};
      end
   end

   // events stick; set wins over the clearing read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         act_pend <= 1'b0;
         inact_pend <= 1'b0;
         awake <= `MLAC_AWAKE_RST;
         wakeup_mode <= 1'b0;
      end
      else
      begin
         // loop mode drops the flag by itself at the following sample
         act_pend <= act_ev | (act_pend & ~stat_rd &
                     ~((link == lk_loop) & new_smp));
         inact_pend <= inact_ev | (inact_pend & ~stat_rd &
                       ~((link == lk_loop) & new_smp));
         if (act_ev)
            awake <= 1'b1;
         else if (inact_ev)
            awake <= 1'b0;
         if (!sleep_ok)
            wakeup_mode <= 1'b0;
         else if (act_ev)
            wakeup_mode <= 1'b0;
         else if (inact_ev)
            wakeup_mode <= 1'b1;
      end
   end

   // awake level on the selected pin, pending events on the other
   wire [1:0] amap = cfg[`MLAC_CFG_MAP_HI:`MLAC_CFG_MAP_LO];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_pin_one <= 1'b0;
         irq_pin_two <= 1'b0;
      end
      else
      begin
         irq_pin_one <= (amap == `MLAC_MAP_PIN1) ? awake : any_pend;
         irq_pin_two <= (amap == `MLAC_MAP_PIN2) ? awake : any_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample store: x, y, z entries tagged by axis
   mlac_phase_t ph;
   wire ftrig = cfg[`MLAC_CFG_FTRIG];
   wire pop = fifo_rd & ~fempty;
   wire push = (ph != ph_idle) & ~frozen & (~ffull | ftrig | pop);
   // triggered mode keeps the newest history by dropping the oldest
   wire drop = push & ffull & ~pop;
   wire [1:0] tag = (ph == ph_x) ? `MLAC_TAG_X :
                    (ph == ph_y) ? `MLAC_TAG_Y : `MLAC_TAG_Z;
   wire mlac_smp_t pdat = (ph == ph_x) ? x_s : (ph == ph_y) ? y_s : z_s;

   always_ff @(posedge pclk)
   begin
      if (push)
         fmem[wp] <= {tag, 2'h0, pdat};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ph <= ph_idle;
         wp <= 9'h000;
         rp <= 9'h000;
         fcnt <= 10'h000;
         frozen <= 1'b0;
      end
      else
      begin
         case (ph)
            ph_idle: ph <= new_smp ? ph_x : ph_idle;
            ph_x: ph <= ph_y;
            ph_y: ph <= ph_z;
            default: ph <= ph_idle;
         endcase
         if (push)
            wp <= wp + 9'h001;
         if (pop | drop)
            rp <= rp + 9'h001;
         if (push & ~pop & ~drop)
            fcnt <= fcnt + 10'h001;
         else if (pop & ~push)
            fcnt <= fcnt - 10'h001;
         if (act_ev & ftrig)
            frozen <= 1'b1;
         else if (!ftrig)
            frozen <= 1'b0;
      end
   end

endmodule : mlac_top
`default_nettype wire

// *** mlac_top_props.sv ***
// port assertions for the motion block
`timescale 1ns/100ps
`default_nettype none
`include "mlac_map.svh"
module mlac_top_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq_pin_one,
   input wire logic irq_pin_two,
   input wire logic wakeup_mode
);
   import mlac_pkg::*;
   logic [9:0] cfg;
   // shadow of the config word, taken where the write lands
   wire cfg_wr = psel && penable && pready && pwrite
      && paddr == `MLAC_OFS_CFG;
   wire sleep_ok = cfg[`MLAC_CFG_AUTOSLEEP] && cfg[5:4] != 2'h0;
   wire [1:0] map = cfg[8:7];
   wire map_on = map == `MLAC_MAP_PIN1 || map == `MLAC_MAP_PIN2;
   wire awake_pin = map == `MLAC_MAP_PIN1 ? irq_pin_one : irq_pin_two;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cfg <= `MLAC_CFG_RST;
      else if (cfg_wr)
         cfg <= pwdata[9:0];
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   a_answer_next: assert property (s_access |=> s_answer)
      else $error("access not answered for one cycle");
   a_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   a_err_decode: assert property (pready |->
      pslverr == (paddr > 8'h48 || paddr[1:0] != 2'h0))
      else $error("slave error does not match address");
   a_err_data: assert property (pslverr |-> prdata == 32'h0)
      else $error("error read returned data");
   a_data_hold: assert property ($changed(prdata) |-> pready)
      else $error("read data moved outside a transfer");
   a_default_awake: assert property (
      !sleep_ok && !$past(sleep_ok) |-> !wakeup_mode)
      else $error("wake-up mode without autosleep in chained mode");
   a_sleep_cause: assert property ($rose(wakeup_mode) |-> sleep_ok)
      else $error("wake-up mode entered without autosleep");
   a_pin_asleep: assert property (wakeup_mode && $past(wakeup_mode, 2)
      && map_on && $stable(map) |-> !awake_pin)
      else $error("mapped pin not showing asleep");
endmodule : mlac_top_props

bind mlac_top mlac_top_props u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two),
   .wakeup_mode(wakeup_mode));
`default_nettype wire

// *** mlac_sensor_model.sv ***
// sensor front end model: paces samples and presents axis data
`timescale 1ns/100ps
`default_nettype none
module mlac_sensor_model (
   input wire logic pclk,
   output logic sample_clk,
   output mlac_pkg::mlac_smp_t x_in,
   output mlac_pkg::mlac_smp_t y_in,
   output mlac_pkg::mlac_smp_t z_in,
   output mlac_pkg::mlac_smp_t t_in
);
   import mlac_pkg::*;
   // pacing clock stands low between samples; 64 ns period back to back
   initial
   begin
      sample_clk = 1'b0;
      {x_in, y_in, z_in, t_in} = '0;
   end
   task send(input mlac_smp_t x, input mlac_smp_t y, input mlac_smp_t z,
      input mlac_smp_t t);
      @(posedge pclk);
      {x_in, y_in, z_in, t_in} <= {x, y, z, t};
      repeat (3) @(posedge pclk);
      sample_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      sample_clk <= 1'b0;
      // hold time over: scramble so stale data is never trusted
      {x_in, y_in, z_in, t_in} <= ~{x, y, z, t};
   endtask : send
endmodule : mlac_sensor_model
`default_nettype wire

// *** mlac_top_bench.sv ***
// self-checking bench for the motion block
`timescale 1ns/100ps
`default_nettype none
module mlac_top_bench;
   import mlac_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, e;
   logic pready, pslverr, irq_pin_one, irq_pin_two, wakeup_mode, sample_clk;
   logic er;
   mlac_smp_t x_in, y_in, z_in, t_in;
   int miscompares = 0;
   int n_tests = 0;
   logic [7:0] v_ofs [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
      8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
   logic [7:0] v_exp [11] = '{8'h12, 8'hfe, 8'h7f, 8'h23, 8'h01, 8'hed,
      8'hff, 8'hff, 8'h07, 8'h56, 8'h04};
   always #4 pclk = ~pclk;
   mlac_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sample_clk(sample_clk), .x_in(x_in), .y_in(y_in), .z_in(z_in),
      .t_in(t_in), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two),
      .wakeup_mode(wakeup_mode));
   mlac_sensor_model u_sensor (.pclk(pclk), .sample_clk(sample_clk),
      .x_in(x_in), .y_in(y_in), .z_in(z_in), .t_in(t_in));
   ////////////////////////////////////////////////////////////
   task check(input string w, input logic [31:0] x, input logic [31:0] s);
      n_tests++;
      if (s !== x)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", w, x, s);
      end
   endtask : check
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no fixed latency assumed; the watchdog ends a silent slave
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      check("pready", 32'h1, 32'(pready));
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task rdc(input logic [7:0] a, input logic [31:0] x, input string w);
      xfer(1'b0, a, 32'h0);
      check(w, x, rd);
   endtask : rdc
   task burst(input mlac_smp_t v, input int n);
      repeat (n) u_sensor.send(v, v, v, v);
      // events reach status and pins a few cycles after the last sample
      repeat (4) @(posedge pclk);
   endtask : burst
   task results;
      if (miscompares == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      miscompares++;
      results();
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("wakeup_mode", 32'h0, 32'(wakeup_mode));
      rdc(8'h30, 32'h0, "cfg");
      rdc(8'h2c, 32'h4, "status");
      xfer(1'b0, 8'h80, 32'h0);
      check("pslverr", 32'h1, 32'(er));
      u_sensor.send(12'h123, 12'hfed, 12'h7ff, 12'h456);
      foreach (v_ofs[i])
      begin
         rdc(v_ofs[i], 32'(v_exp[i]), "view");
      end
      rdc(8'h48, 32'h3, "count");
      rdc(8'h44, 32'h0123, "entry");
      rdc(8'h44, 32'h4fed, "entry");
      rdc(8'h44, 32'h87ff, "entry");
      rdc(8'h44, 32'h0, "empty");
      for (int i = 0; i < 171; i++)
      begin
         u_sensor.send(12'(i), 12'h0, 12'h0, 12'h0);
      end
      repeat (4) @(posedge pclk);
      rdc(8'h48, 32'h200, "full");
      for (int k = 0; k < 512; k++)
      begin
         e = (k % 3 == 0) ? 32'(k / 3) : 32'(k % 3) << 14;
         rdc(8'h44, e, "entry");
      end
      rdc(8'h48, 32'h0, "drained");
      wr(8'h34, 32'd100);
      wr(8'h38, 32'd50);
      wr(8'h3c, 32'd2);
      wr(8'h40, 32'd3);
      wr(8'h30, 32'h0c3);
      burst(12'h000, 3);
      rdc(8'h2c, 32'h4, "status");
      burst(12'h000, 1);
      check("pin one", 32'h0, 32'(irq_pin_one));
      check("pin two", 32'h1, 32'(irq_pin_two));
      check("wakeup", 32'h0, 32'(wakeup_mode));
      rdc(8'h2c, 32'h2, "status");
      rdc(8'h2c, 32'h0, "status");
      burst(12'h0c8, 1);
      rdc(8'h2c, 32'h0, "status");
      burst(12'h0c8, 1);
      rdc(8'h2c, 32'h5, "status");
      wr(8'h30, 32'h0);
      wr(8'h30, 32'h153);
      burst(12'h000, 4);
      check("wakeup", 32'h1, 32'(wakeup_mode));
      check("pin two", 32'h0, 32'(irq_pin_two));
      burst(12'h0c8, 2);
      rdc(8'h2c, 32'ha, "status");
      rdc(8'h2c, 32'h8, "status");
      burst(12'h0c8, 2);
      check("wakeup", 32'h0, 32'(wakeup_mode));
      check("pin two", 32'h1, 32'(irq_pin_two));
      rdc(8'h2c, 32'h5, "status");
      burst(12'h0c8, 3);
      rdc(8'h2c, 32'h4, "status");
      wr(8'h30, 32'h0);
      wr(8'h30, 32'h023);
      burst(12'h000, 3);
      check("pin one", 32'h1, 32'(irq_pin_one));
      burst(12'h000, 1);
      check("pin one", 32'h0, 32'(irq_pin_one));
      rdc(8'h2c, 32'h0, "status");
      burst(12'h0c8, 2);
      rdc(8'h2c, 32'h5, "status");
      wr(8'h30, 32'h00a);
      burst(12'h400, 3);
      burst(12'h480, 1);
      burst(12'h400, 2);
      rdc(8'h2c, 32'h4, "status");
      burst(12'h400, 1);
      rdc(8'h2c, 32'h2, "status");
      wr(8'h30, 32'h201);
      burst(12'h0c8, 3);
      rdc(8'h2c, 32'h15, "status");
      rdc(8'h48, 32'h60, "frozen");
      burst(12'h0c8, 1);
      rdc(8'h48, 32'h60, "frozen");
      results();
   end
endmodule : mlac_top_bench
`default_nettype wire
